//--- src/programmable_state_sequencer.sv
// Programmable sequencer: AND array, OR array, complement NOR and set/reset registers.
// Assumes the program ports are held static by the system; external inputs are asynchronous pins.
//
// Functional notes
// - Next state and output depend on state and inputs
// - States held in register; jumps only on terms
// - Machine output comes from a registered stage
// - Taken jump changes state or output only if programmed
// - Transitions are ANDs of state and input literals
// - True term loads next state at clock edge
// - Arrays drive stage set/reset; state fed back
// - Output register holds unless changed by term
// - Sixteen inputs plus six state bits, 22 buffers
// - Each literal true, complement or don't care
// - Both links intact forces term false
// - Terms have 44 buffer links plus complement link
// - All terms reach state and 8-bit output registers
// - Term count selectable, 48 or 64
// - Set and reset OR pair per stage, 14 stages
// - Complement is NOR of linked terms, fed back
`timescale 1ns/1ns

module programmable_state_sequencer #(
  parameter int NUM_TERMS = sequencer_pkg::TERMS_BASE
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [sequencer_pkg::EXT_INPUTS-1:0] external_input_line,
  input wire sequencer_pkg::term_prog_t term_prog [NUM_TERMS],
  input wire logic [NUM_TERMS-1:0] set_map [sequencer_pkg::STAGES],
  input wire logic [NUM_TERMS-1:0] reset_map [sequencer_pkg::STAGES],
  input wire logic [NUM_TERMS-1:0] comp_map,
  output logic [sequencer_pkg::STATE_BITS-1:0] state_feedback_line,
  output logic [sequencer_pkg::OUT_BITS-1:0] output_register_bit
);

  // ==========================================================================
  // Input synchroniser
  logic [sequencer_pkg::EXT_INPUTS-1:0] ext_meta_r;
  logic [sequencer_pkg::EXT_INPUTS-1:0] ext_sync_r;
  logic [sequencer_pkg::EXT_INPUTS-1:0] ext_meta_nxt;
  logic [sequencer_pkg::EXT_INPUTS-1:0] ext_sync_nxt;

  always_comb begin
    ext_meta_nxt = external_input_line;
    ext_sync_nxt = ext_meta_r;
  end

  // Costs two cycles of input latency; a pin change is seen on the third edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_meta_r <= '0;
      ext_sync_r <= '0;
    end else begin
      ext_meta_r <= ext_meta_nxt;
      ext_sync_r <= ext_sync_nxt;
    end
  end

  // ==========================================================================
  // True/complement buffers
  logic [sequencer_pkg::STAGES-1:0] stage_r;
  logic [sequencer_pkg::STAGES-1:0] stage_nxt;
  logic [sequencer_pkg::BUFFERS-1:0] lit;

  // External inputs plus internal state feedback
  assign lit = {stage_r[sequencer_pkg::STAGE_STATE_LSB +: sequencer_pkg::STATE_BITS],
                ext_sync_r};

  // ==========================================================================
  // AND array
  logic [NUM_TERMS-1:0] base_term;
  logic [NUM_TERMS-1:0] dead_term;
  logic [NUM_TERMS-1:0] transition_term;
  logic comp_line;
  logic [NUM_TERMS-1:0] comp_users;

  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    logic base_t;
    logic dead_t;
    always_comb begin
      base_t = 1'b1;
      dead_t = 1'b0;
      for (int b = 0; b < sequencer_pkg::BUFFERS; b++) begin
        // Open link is don't care; intact link demands its polarity
        if (term_prog[t].links[2*b+sequencer_pkg::LINK_TRUE_OFS] && !lit[b]) begin
          base_t = 1'b0;
        end
        if (term_prog[t].links[2*b+sequencer_pkg::LINK_COMP_OFS] && lit[b]) begin
          base_t = 1'b0;
        end
        // Both intact can never be met
        if (term_prog[t].links[2*b+sequencer_pkg::LINK_TRUE_OFS] &&
            term_prog[t].links[2*b+sequencer_pkg::LINK_COMP_OFS]) begin
          dead_t = 1'b1;
        end
      end
    end
    assign base_term[t] = base_t;
    assign dead_term[t] = dead_t;
    assign comp_users[t] = term_prog[t].comp_link;
    // 45th input: complement feedback gates the term when linked
    assign transition_term[t] = base_t & (comp_line | ~term_prog[t].comp_link);
  end

  // ==========================================================================
  // Complement array
  // Terms feeding the NOR contribute their direct value; this breaks the
  // combinational loop, so a linked term cannot itself use the complement.
  assign comp_line = ~|(base_term & comp_map);

  // ==========================================================================
  // OR array and stage registers
  sequencer_pkg::stage_cmd_t [sequencer_pkg::STAGES-1:0] cmd;

  for (genvar s = 0; s < sequencer_pkg::STAGES; s++) begin : g_stage
    // Set/reset OR pair per stage over all terms
    assign cmd[s].set = |(transition_term & set_map[s]);
    assign cmd[s].clr = |(transition_term & reset_map[s]);
  end

  always_comb begin
    stage_nxt = stage_r;
    for (int s = 0; s < sequencer_pkg::STAGES; s++) begin
      // Idle stage holds, so state and output move only on terms
      unique case ({cmd[s].set, cmd[s].clr})
        2'b10: stage_nxt[s] = 1'b1;
        2'b01: stage_nxt[s] = 1'b0;
        2'b11: stage_nxt[s] = ~stage_r[s];
        2'b00: stage_nxt[s] = stage_r[s];
      endcase
    end
  end

  // State change on a jump relies on the program naming a new state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_r <= {sequencer_pkg::OUT_INIT, sequencer_pkg::STATE_INIT};
    end else begin
      stage_r <= stage_nxt;
    end
  end

  // Outputs come only from the register, never from the arrays
  assign state_feedback_line = stage_r[sequencer_pkg::STAGE_STATE_LSB +: sequencer_pkg::STATE_BITS];
  assign output_register_bit = stage_r[sequencer_pkg::STAGE_OUT_LSB +: sequencer_pkg::OUT_BITS];

  // ==========================================================================
  // Assertions
  logic [sequencer_pkg::STAGES-1:0] set_v;
  logic [sequencer_pkg::STAGES-1:0] clr_v;
  logic [sequencer_pkg::STAGES-1:0] only_set;
  logic [sequencer_pkg::STAGES-1:0] only_clr;
  logic [sequencer_pkg::STAGES-1:0] both_v;

  always_comb begin
    for (int s = 0; s < sequencer_pkg::STAGES; s++) begin
      set_v[s] = cmd[s].set;
      clr_v[s] = cmd[s].clr;
    end
    only_set = set_v & ~clr_v;
    only_clr = clr_v & ~set_v;
    both_v = set_v & clr_v;
  end

  a_stage_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    (set_v == '0 && clr_v == '0) |=> $stable(stage_r))
    else $error("stage register changed without any term");

  a_set_loads: assert property (
    @(posedge clk_sys) disable iff (rst)
    (only_set != '0) |=> ((stage_r & $past(only_set)) == $past(only_set)))
    else $error("set stage did not load one");

  a_clr_loads: assert property (
    @(posedge clk_sys) disable iff (rst)
    (only_clr != '0) |=> ((stage_r & $past(only_clr)) == '0))
    else $error("reset stage did not load zero");

  a_both_toggle: assert property (
    @(posedge clk_sys) disable iff (rst)
    (both_v != '0) |=> (((stage_r ^ $past(stage_r)) & $past(both_v)) == $past(both_v)))
    else $error("stage with set and reset did not toggle");

  a_dead_term: assert property (
    @(posedge clk_sys) disable iff (rst)
    (transition_term & dead_term) == '0)
    else $error("term with conflicting links was true");

  a_comp_nor: assert property (
    @(posedge clk_sys) disable iff (rst)
    ((transition_term & comp_users) != '0) |-> ((base_term & comp_map) == '0))
    else $error("complement jump fired while a linked term was true");

  a_out_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    ((set_v[sequencer_pkg::STAGE_OUT_LSB +: sequencer_pkg::OUT_BITS] |
      clr_v[sequencer_pkg::STAGE_OUT_LSB +: sequencer_pkg::OUT_BITS]) == '0)
    |=> $stable(output_register_bit))
    else $error("output register changed with no output command");

  a_input_sync: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(rst, 2) |-> (ext_sync_r == $past(external_input_line, 2)))
    else $error("synchronised input does not lag pin by two cycles");

  a_reset_init: assert property (
    @(posedge clk_sys)
    rst |=> (state_feedback_line == sequencer_pkg::STATE_INIT &&
             output_register_bit == sequencer_pkg::OUT_INIT) || !rst)
    else $error("registers not at initial value during reset");

  c_jump_taken: cover property (
    @(posedge clk_sys) disable iff (rst)
    (transition_term != '0) ##1 $changed(state_feedback_line));

  c_output_change: cover property (
    @(posedge clk_sys) disable iff (rst)
    $changed(output_register_bit));

  c_comp_jump: cover property (
    @(posedge clk_sys) disable iff (rst)
    comp_line && ((transition_term & ~comp_map) != '0));

  c_toggle: cover property (
    @(posedge clk_sys) disable iff (rst)
    both_v != '0);

endmodule : programmable_state_sequencer

//--- src/sequencer_pkg.sv
// Constants and carrier types for the programmable state sequencer.
// Assumes one system clock; the program arrives as static configuration on that clock.
package sequencer_pkg;

  // ==========================================================================
  // Array dimensions
  localparam int EXT_INPUTS = 16;
  localparam int STATE_BITS = 6;
  localparam int OUT_BITS = 8;
  localparam int STAGES = STATE_BITS + OUT_BITS;
  localparam int BUFFERS = EXT_INPUTS + STATE_BITS;
  localparam int LINKS = 2 * BUFFERS;
  localparam int TERMS_BASE = 48;
  localparam int TERMS_LARGE = 64;

  // ==========================================================================
  // Field positions of the buffer vector and of the stage register
  localparam int BUF_EXT_LSB = 0;
  localparam int BUF_STATE_LSB = EXT_INPUTS;
  localparam int STAGE_STATE_LSB = 0;
  localparam int STAGE_OUT_LSB = STATE_BITS;
  localparam int LINK_TRUE_OFS = 0;
  localparam int LINK_COMP_OFS = 1;

  // ==========================================================================
  // Reset values
  localparam logic [STATE_BITS-1:0] STATE_INIT = 6'h00;
  localparam logic [OUT_BITS-1:0] OUT_INIT = 8'h00;

  // One AND gate: a set bit is an intact link
  typedef struct packed {
    logic comp_link;
    logic [LINKS-1:0] links;
  } term_prog_t;

  // Set/reset command for one stage
  typedef struct packed {
    logic set;
    logic clr;
  } stage_cmd_t;

endpackage : sequencer_pkg

//--- tb/system_logic_model.sv
// Model of the system logic that drives the sequencer's pins.
// Assumes the bench hands it pin values just after a rising edge.
`timescale 1ns/1ns

module system_logic_model (
  input wire logic [15:0] pins_req,
  input wire logic fb_en,
  input wire logic [sequencer_pkg::OUT_BITS-1:0] output_register_bit,
  output logic [sequencer_pkg::EXT_INPUTS-1:0] external_input_line
);
  // ==========================================================================
  // Pin drive
  // The loop from output bit 0 to the top pin widens the state outside the block
  always_comb begin
    external_input_line = pins_req;
    if (fb_en) begin
      external_input_line[15] = output_register_bit[0];
    end
  end
endmodule : system_logic_model

//--- tb/programmable_state_sequencer_tb.sv
// Self-checking bench for the programmable state sequencer.
// Assumes the program ports stay static after time zero.
`timescale 1ns/1ns

module programmable_state_sequencer_tb;
  localparam int NT = sequencer_pkg::TERMS_BASE;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] pins_req = 16'h0000;
  logic fb_en = 1'b0;
  logic [15:0] ext;
  sequencer_pkg::term_prog_t prog [NT];
  logic [NT-1:0] smap [sequencer_pkg::STAGES];
  logic [NT-1:0] rmap [sequencer_pkg::STAGES];
  logic [NT-1:0] cmap;
  logic [5:0] st;
  logic [7:0] ob;
  logic [13:0] exp_q [$];
  event chk_ev;
  int n_errors = 0;
  int checked = 0;

  // ==========================================================================
  // Clock, partner and design
  always #20 clk_sys = ~clk_sys;

  system_logic_model model (.pins_req(pins_req), .fb_en(fb_en),
    .output_register_bit(ob), .external_input_line(ext));

  programmable_state_sequencer #(.NUM_TERMS(NT)) uut (.clk_sys(clk_sys), .rst(rst),
    .external_input_line(ext), .term_prog(prog), .set_map(smap), .reset_map(rmap),
    .comp_map(cmap), .state_feedback_line(st), .output_register_bit(ob));

  // ==========================================================================
  // Tasks
  task automatic link(input int t, input int b, input int c);
    prog[t].links[2*b+c] = 1'b1;
  endtask : link

  // Random bits land only on pins that every term ignores; pin 15 is kept for feedback
  task automatic drive(input logic [15:0] v);
    @(posedge clk_sys);
    #1 pins_req = v | (16'($urandom) & 16'h7FE0);
  endtask : drive

  task automatic chk(input int n, input logic [5:0] s, input logic [7:0] o);
    repeat (n) @(posedge clk_sys);
    #2 exp_q.push_back({s, o});
    -> chk_ev;
  endtask : chk

  task automatic stop_test();
    $display("Errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Result watcher
  always @(chk_ev) begin : watch
    logic [13:0] e;
    e = exp_q.pop_front();
    checked++;
    if ({st, ob} !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, {st, ob}, e);
    end
  end

  initial begin
    #1000000 n_errors++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    cmap = '0;
    for (int s = 0; s < sequencer_pkg::STAGES; s++) begin
      smap[s] = '0;
      rmap[s] = '0;
    end
    // Unused terms keep a both-intact pair so they stay false
    for (int t = 0; t < NT; t++) begin
      prog[t] = '0;
      link(t, 0, 0);
      link(t, 0, 1);
    end
    prog[0] = '0;
    link(0, 0, 0);
    link(0, 1, 0);
    link(0, 16, 1);
    smap[0][0] = 1'b1;
    smap[6][0] = 1'b1;
    prog[1] = '0;
    link(1, 2, 0);
    link(1, 16, 0);
    rmap[0][1] = 1'b1;
    link(2, 3, 0);
    smap[1][2] = 1'b1;
    prog[3] = '0;
    prog[3].comp_link = 1'b1;
    link(3, 16, 0);
    cmap[1] = 1'b1;
    smap[2][3] = 1'b1;
    prog[4] = '0;
    link(4, 4, 0);
    smap[8][4] = 1'b1;
    rmap[8][4] = 1'b1;
    prog[5] = '0;
    link(5, 15, 0);
    link(5, 4, 0);
    smap[9][5] = 1'b1;
    void'($urandom(32'hB1817962));
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk(0, 6'h00, 8'h00);
    drive(16'h000B);
    chk(3, 6'h01, 8'h01);
    chk(1, 6'h05, 8'h01);
    chk(4, 6'h05, 8'h01);
    @(posedge clk_sys);
    #1 fb_en = 1'b1;
    drive(16'h000E);
    chk(3, 6'h04, 8'h01);
    drive(16'h0010);
    drive(16'h0000);
    chk(2, 6'h04, 8'h0D);
    drive(16'h0010);
    drive(16'h0000);
    chk(2, 6'h04, 8'h09);
    @(posedge clk_sys);
    #1 rst = 1'b1;
    chk(0, 6'h00, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    drive(16'h0003);
    chk(3, 6'h01, 8'h01);
    for (int i = 0; i < 8; i++) begin
      drive(16'h0003);
      chk(1, 6'h05, 8'h01);
    end
    @(posedge clk_sys);
    #3 stop_test();
  end
endmodule : programmable_state_sequencer_tb
